/* flash_regs.svh */
// Register offsets, field positions, address map and timing counts of the flash block.
// Assumes a byte-addressed register port with word-aligned offsets.
`ifndef FLASH_REGS_SVH
`define FLASH_REGS_SVH

`define FLASH_REG_MEMCFG 8'h00
`define FLASH_REG_FETCH_FLG 8'h04
`define FLASH_REG_LOAD_FLG 8'h08
`define FLASH_REG_IRQ_EN 8'h0C
`define FLASH_REG_CMD_ADDR 8'h10
`define FLASH_REG_CMD_DATA 8'h14
`define FLASH_REG_CMD 8'h18
`define FLASH_REG_STATUS 8'h1C
`define FLASH_REG_PROT 8'h20

`define FLASH_ALIAS_BIT 0
`define FLASH_PROT_BIT 0
`define FLASH_BOOT_LSB 8
`define FLASH_STAT_BUSY_BIT 0
`define FLASH_STAT_REFUSED_BIT 1
`define FLASH_BOOT_RESET 6'h01

`define FLASH_ALIAS_BASE 32'h0000_0000
`define FLASH_MAIN_BASE 32'h1000_0000
`define FLASH_WINDOW_BYTES 32'h0000_8000
`define FLASH_SRAM_BASE 32'h2000_0000
`define FLASH_SRAM_LAST 32'h2000_07FF
`define FLASH_SMU_BASE 32'h4000_0000
`define FLASH_SMU_LAST 32'h4000_03FF
`define FLASH_FCREG_BASE 32'h4000_0800
`define FLASH_FCREG_LAST 32'h4000_0BFF
`define FLASH_INFO_BASE 32'h4000_0C00
`define FLASH_INFO_LAST 32'h4000_0FFF
`define FLASH_PERIPH_BASE 32'h4000_1000
`define FLASH_PERIPH_LAST 32'h4000_1BFF
`define FLASH_PPB_BASE 32'hE000_0000
`define FLASH_PPB_LAST 32'hE00F_FFFF

`define FLASH_WORDS_PER_PAGE 128
`define FLASH_PAGE_SHIFT 7
`define FLASH_INFO_IDX_W 7
`define FLASH_CODE_W 39

`define FLASH_CLK_PERIOD_NS 20
`define FLASH_WRITE_TIME_NS 40000
`define FLASH_ERASE_TIME_NS 20000000
`define FLASH_WRITE_CYCLES ((`FLASH_WRITE_TIME_NS + `FLASH_CLK_PERIOD_NS - 1) / `FLASH_CLK_PERIOD_NS)
`define FLASH_ERASE_CYCLES ((`FLASH_ERASE_TIME_NS + `FLASH_CLK_PERIOD_NS - 1) / `FLASH_CLK_PERIOD_NS)

`endif

/* flash_pkg.sv */
// Types shared by the flash block and its testbench.
// Assumes one clock domain; all structs are packed.
package flash_pkg;

  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_WRITE_WORD = 2'h1,
    CMD_ERASE_PAGE = 2'h2,
    CMD_ERASE_PROGRAM = 2'h3
  } fc_cmd_t;

  typedef enum logic [1:0] {
    FC_IDLE = 2'b00,
    FC_CHECK = 2'b01,
    FC_RUN = 2'b11,
    FC_DONE = 2'b10
  } fc_state_t;

  typedef struct packed {
    logic uncorr;
    logic corr;
    logic erased;
  } err_flags_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic debug;
    logic [1:0] size;
    logic [31:0] addr;
  } sys_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic pass;
    logic [31:0] data;
  } sys_rsp_t;

  typedef struct packed {
    logic valid;
    logic [6:0] idx;
    logic [31:0] data;
  } info_load_t;

  typedef struct packed {
    logic [31:0] data;
    logic single;
    logic double;
  } ecc_result_t;

endpackage : flash_pkg

/* flash_memory_access_ecc.sv */
// Flash subsystem: address decode, alias at zero, ECC storage, command sequencer, error flags.
// Assumes the system bus and register port run on clk_i; a read answers one cycle later.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "flash_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module flash_memory_access_ecc #(
  parameter int FLASH_WORDS = 8192,
  parameter int WRITE_CYCLES = `FLASH_WRITE_CYCLES,
  parameter int ERASE_CYCLES = `FLASH_ERASE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire flash_pkg::sys_req_t sys_req_i,
  output flash_pkg::sys_rsp_t sys_rsp_o,
  input wire flash_pkg::info_load_t info_load_i,
  output logic irq_o,
  output logic nmi_o
);
  import flash_pkg::*;

  localparam int PAGES = FLASH_WORDS / `FLASH_WORDS_PER_PAGE;
  localparam int IDX_W = $clog2(FLASH_WORDS);
  localparam int BOOT_W = $clog2(PAGES);
  localparam int TIMER_W = 24;
  localparam int INFO_WORDS = 1 << `FLASH_INFO_IDX_W;

  if (FLASH_WORDS < 2 * `FLASH_WORDS_PER_PAGE || FLASH_WORDS > 8192
      || (FLASH_WORDS & (FLASH_WORDS - 1)) != 0 || WRITE_CYCLES < 1 || ERASE_CYCLES < 1
      || WRITE_CYCLES >= (1 << TIMER_W) || ERASE_CYCLES >= (1 << TIMER_W))
  begin : g_bad_params
    $error("Flash size must be a power of two from 256 to 8192; counts must fit the timer");
  end

  typedef struct packed {
    logic [FLASH_WORDS-1:0][`FLASH_CODE_W-1:0] mem;
    logic [INFO_WORDS-1:0][`FLASH_CODE_W-1:0] info;
    logic alias_sram;
    err_flags_t fetch_flg;
    err_flags_t load_flg;
    logic [3:0] irq_en;
    logic [31:0] cmd_addr;
    logic [31:0] cmd_data;
    fc_cmd_t cmd;
    fc_state_t fsm;
    logic [TIMER_W-1:0] timer;
    logic refused;
    logic prot;
    logic [BOOT_W-1:0] boot_blocks;
    logic [31:0] reg_rdata;
    sys_rsp_t rsp;
    logic irq;
    logic nmi;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  ////////////////////////////////////////////////////////////////////////////////
  // Single-error-correct, double-error-detect code: bit 0 is overall parity,
  // positions 1..38 form a Hamming layout with check bits at powers of two.
  function automatic logic [`FLASH_CODE_W-1:0] ecc_encode(input logic [31:0] d);
    logic [`FLASH_CODE_W-1:0] cw;
    logic [5:0] s;
    int k;
    cw = '0;
    s = '0;
    k = 0;
    for (int p = 1; p < `FLASH_CODE_W; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        cw[p] = d[k];
        k++;
      end
    end
    for (int p = 1; p < `FLASH_CODE_W; p++)
    begin
      if (cw[p])
        s = s ^ p[5:0];
    end
    for (int i = 0; i < 6; i++)
      cw[1 << i] = s[i];
    cw[0] = ^cw[`FLASH_CODE_W-1:1];
    return cw;
  endfunction : ecc_encode

  function automatic ecc_result_t ecc_decode(input logic [`FLASH_CODE_W-1:0] cw);
    ecc_result_t r;
    logic [`FLASH_CODE_W-1:0] fixed;
    logic [5:0] s;
    logic par;
    int k;
    r = '0;
    s = '0;
    k = 0;
    par = ^cw;
    fixed = cw;
    for (int p = 1; p < `FLASH_CODE_W; p++)
    begin
      if (cw[p])
        s = s ^ p[5:0];
    end
    if (par && s < 6'(`FLASH_CODE_W))
    begin
      fixed[s] = ~fixed[s];
      r.single = 1'b1;
    end
    r.double = (!par && s != 6'h00) || (par && s >= 6'(`FLASH_CODE_W));
    for (int p = 1; p < `FLASH_CODE_W; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        r.data[k] = fixed[p];
        k++;
      end
    end
    return r;
  endfunction : ecc_decode

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
    return a >= lo && a <= hi;
  endfunction : in_range

  ////////////////////////////////////////////////////////////////////////////////
  logic [31:0] a;
  logic hit_alias;
  logic hit_main;
  logic hit_info;
  logic hit_other;
  logic [IDX_W-1:0] widx;
  logic [`FLASH_INFO_IDX_W-1:0] iidx;
  logic [`FLASH_CODE_W-1:0] raw;
  ecc_result_t dec;
  logic raw_erased;
  logic [BOOT_W-1:0] boot_eff;
  logic [IDX_W-1:0] cmd_idx;
  logic [BOOT_W-1:0] cmd_page;
  logic cmd_in_boot;
  logic cmd_in_range;

  always_comb
  begin
    a = sys_req_i.addr;
    hit_alias = a < `FLASH_ALIAS_BASE + `FLASH_WINDOW_BYTES;
    hit_main = in_range(a, `FLASH_MAIN_BASE,
                        `FLASH_MAIN_BASE + 32'(FLASH_WORDS * 4) - 32'h1);
    hit_info = in_range(a, `FLASH_INFO_BASE, `FLASH_INFO_LAST);
    hit_other = in_range(a, `FLASH_SRAM_BASE, `FLASH_SRAM_LAST)
      || in_range(a, `FLASH_SMU_BASE, `FLASH_SMU_LAST)
      || in_range(a, `FLASH_FCREG_BASE, `FLASH_FCREG_LAST)
      || in_range(a, `FLASH_PERIPH_BASE, `FLASH_PERIPH_LAST)
      || in_range(a, `FLASH_PPB_BASE, `FLASH_PPB_LAST);
    widx = a[IDX_W+1:2];
    iidx = a[`FLASH_INFO_IDX_W+1:2]; // Page bit ignored: both pages read one copy
    raw = hit_info ? st_ff.info[iidx] : st_ff.mem[widx];
    raw_erased = &raw;
    dec = ecc_decode(raw);
    // Zero would leave boot empty; the field tops out one page short of the end
    boot_eff = (st_ff.boot_blocks == '0) ? BOOT_W'(1) : st_ff.boot_blocks;
    cmd_idx = st_ff.cmd_addr[IDX_W+1:2];
    cmd_page = cmd_idx[IDX_W-1:`FLASH_PAGE_SHIFT];
    cmd_in_boot = cmd_page < boot_eff;
    cmd_in_range = in_range(st_ff.cmd_addr, `FLASH_MAIN_BASE,
                            `FLASH_MAIN_BASE + 32'(FLASH_WORDS * 4) - 32'h1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic is_flash;
    logic ok;
    err_flags_t hit_flags;
    nxt_st = st_ff;
    is_flash = 1'b0;
    ok = 1'b0;
    hit_flags = '0;

    // Register port
    nxt_st.reg_rdata = '0;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        `FLASH_REG_MEMCFG: nxt_st.reg_rdata[`FLASH_ALIAS_BIT] = st_ff.alias_sram;
        `FLASH_REG_FETCH_FLG: nxt_st.reg_rdata[2:0] = st_ff.fetch_flg;
        `FLASH_REG_LOAD_FLG: nxt_st.reg_rdata[2:0] = st_ff.load_flg;
        `FLASH_REG_IRQ_EN: nxt_st.reg_rdata[3:0] = st_ff.irq_en;
        `FLASH_REG_CMD_ADDR: nxt_st.reg_rdata = st_ff.cmd_addr;
        `FLASH_REG_CMD_DATA: nxt_st.reg_rdata = st_ff.cmd_data;
        `FLASH_REG_CMD: nxt_st.reg_rdata[1:0] = st_ff.cmd;
        `FLASH_REG_STATUS:
        begin
          nxt_st.reg_rdata[`FLASH_STAT_BUSY_BIT] = st_ff.fsm != FC_IDLE;
          nxt_st.reg_rdata[`FLASH_STAT_REFUSED_BIT] = st_ff.refused;
        end
        `FLASH_REG_PROT:
        begin
          nxt_st.reg_rdata[`FLASH_PROT_BIT] = st_ff.prot;
          nxt_st.reg_rdata[`FLASH_BOOT_LSB+BOOT_W-1:`FLASH_BOOT_LSB] = st_ff.boot_blocks;
        end
        default: nxt_st.reg_rdata = '0;
      endcase
    end
    if (reg_wr_i)
    begin
      case (reg_addr_i)
        `FLASH_REG_MEMCFG: nxt_st.alias_sram = reg_wdata_i[`FLASH_ALIAS_BIT];
        `FLASH_REG_FETCH_FLG: nxt_st.fetch_flg = st_ff.fetch_flg & ~reg_wdata_i[2:0];
        `FLASH_REG_LOAD_FLG: nxt_st.load_flg = st_ff.load_flg & ~reg_wdata_i[2:0];
        `FLASH_REG_IRQ_EN: nxt_st.irq_en = reg_wdata_i[3:0];
        `FLASH_REG_CMD_ADDR: nxt_st.cmd_addr = reg_wdata_i;
        `FLASH_REG_CMD_DATA: nxt_st.cmd_data = reg_wdata_i;
        `FLASH_REG_CMD:
        begin
          // A command while busy is dropped; the sequencer owns the array
          if (st_ff.fsm == FC_IDLE && reg_wdata_i[1:0] != CMD_NONE)
          begin
            nxt_st.cmd = fc_cmd_t'(reg_wdata_i[1:0]);
            nxt_st.fsm = FC_CHECK;
            nxt_st.refused = 1'b0;
          end
        end
        `FLASH_REG_PROT:
        begin
          // Protection can be switched on but only reset switches it off
          nxt_st.prot = st_ff.prot | reg_wdata_i[`FLASH_PROT_BIT];
          if (!st_ff.prot)
            nxt_st.boot_blocks = reg_wdata_i[`FLASH_BOOT_LSB+BOOT_W-1:`FLASH_BOOT_LSB];
        end
        default: nxt_st.prot = st_ff.prot;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // System bus read port
    nxt_st.rsp = '0;
    if (sys_req_i.valid)
    begin
      nxt_st.rsp.valid = 1'b1;
      if (hit_alias && st_ff.alias_sram)
        nxt_st.rsp.pass = 1'b1;
      else if (hit_main || hit_alias || hit_info)
      begin
        is_flash = 1'b1;
        // Direct writes are never allowed; main array contents change only by command
        if (sys_req_i.write || sys_req_i.size == 2'h3)
          nxt_st.rsp.err = 1'b1;
        else if (sys_req_i.debug && st_ff.prot && !hit_info)
          nxt_st.rsp.err = 1'b1;
        else
          ok = 1'b1;
      end
      else if (hit_other)
        nxt_st.rsp.pass = 1'b1;
      else
        nxt_st.rsp.err = 1'b1;
    end
    if (is_flash && ok)
    begin
      nxt_st.rsp.data = dec.data; // Whole word returned; the master picks its lanes
      hit_flags.erased = raw_erased;
      hit_flags.corr = !raw_erased && dec.single;
      hit_flags.uncorr = !raw_erased && dec.double;
    end
    // Set after clear so that an event in the clearing cycle is kept
    if (sys_req_i.fetch)
      nxt_st.fetch_flg = nxt_st.fetch_flg | hit_flags;
    else
      nxt_st.load_flg = nxt_st.load_flg | hit_flags;

    ////////////////////////////////////////////////////////////////////////////////
    // Command sequencer
    case (st_ff.fsm)
      FC_IDLE: nxt_st.timer = '0;
      FC_CHECK:
      begin
        nxt_st.fsm = FC_RUN;
        nxt_st.timer = (st_ff.cmd == CMD_WRITE_WORD) ? TIMER_W'(WRITE_CYCLES)
          : TIMER_W'(ERASE_CYCLES);
        if (st_ff.cmd != CMD_ERASE_PROGRAM && !cmd_in_range)
          nxt_st.refused = 1'b1;
        if (st_ff.cmd != CMD_ERASE_PROGRAM && st_ff.prot && cmd_in_boot)
          nxt_st.refused = 1'b1;
        if (nxt_st.refused)
          nxt_st.fsm = FC_IDLE;
      end
      FC_RUN:
      begin
        nxt_st.timer = st_ff.timer - TIMER_W'(1);
        if (st_ff.timer == TIMER_W'(1))
          nxt_st.fsm = FC_DONE;
      end
      FC_DONE:
      begin
        nxt_st.fsm = FC_IDLE;
        nxt_st.cmd = CMD_NONE;
        if (st_ff.cmd == CMD_WRITE_WORD)
          nxt_st.mem[cmd_idx] = ecc_encode(st_ff.cmd_data);
        for (int i = 0; i < FLASH_WORDS; i++)
        begin
          // Erase granule is the page: the word's page index alone selects
          if ((st_ff.cmd == CMD_ERASE_PAGE && (i >> `FLASH_PAGE_SHIFT) == int'(cmd_page))
              || (st_ff.cmd == CMD_ERASE_PROGRAM
              && (i >> `FLASH_PAGE_SHIFT) >= int'(boot_eff)))
            nxt_st.mem[i] = '1;
        end
      end
      default: nxt_st.fsm = FC_IDLE;
    endcase

    // Information region is filled only by the manufacturing load port
    if (info_load_i.valid)
      nxt_st.info[info_load_i.idx] = ecc_encode(info_load_i.data);
    // Interrupt outputs follow the flags as levels
    nxt_st.irq = |({nxt_st.fetch_flg.corr, nxt_st.load_flg} & st_ff.irq_en);
    nxt_st.nmi = nxt_st.fetch_flg.erased | nxt_st.fetch_flg.uncorr;

    if (rst_i)
    begin
      // Every register clears, so flash is back at zero; only the boundary differs
      nxt_st = '0;
      nxt_st.boot_blocks = BOOT_W'(`FLASH_BOOT_RESET);
      // Array contents are non-volatile and survive reset
      nxt_st.mem = st_ff.mem;
      nxt_st.info = st_ff.info;
    end
  end

  always_ff @(posedge clk_i)
  begin
    st_ff <= nxt_st;
  end

  assign reg_rdata_o = st_ff.reg_rdata;
  assign sys_rsp_o = st_ff.rsp;
  assign irq_o = st_ff.irq;
  assign nmi_o = st_ff.nmi;

endmodule : flash_memory_access_ecc

/* flash_chk_assertions.sv */
// Checker for the flash block's system port, alias select and interrupt outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module flash_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire flash_pkg::sys_req_t sys_req_i,
  input wire flash_pkg::sys_rsp_t sys_rsp_o,
  input wire logic irq_o,
  input wire logic nmi_o
);
  import flash_pkg::*;
  typedef struct packed {logic zsel; logic prot;} shadow_t;
  shadow_t s_ff, nxt_s;
  logic rd_ok, main_a, zero_a;
  assign main_a = sys_req_i.addr[31:15] == 17'h02000;
  assign zero_a = sys_req_i.addr[31:15] == 17'h00000;
  assign rd_ok = sys_req_i.valid && !sys_req_i.write && !sys_req_i.debug
    && sys_req_i.size != 2'h3;
  // Shadow of alias select and the set-only protection bit
  always_comb
  begin
    nxt_s = s_ff;
    if (reg_wr_i && reg_addr_i == 8'h00) nxt_s.zsel = reg_wdata_i[0];
    if (reg_wr_i && reg_addr_i == 8'h20 && reg_wdata_i[0]) nxt_s.prot = 1'b1;
  end
  always_ff @(posedge clk_i)
  begin
    s_ff <= rst_i ? '0 : nxt_s;
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_rsp_follows: assert property (sys_req_i.valid |=> sys_rsp_o.valid)
    else $error("no response after request");
  chk_gap_error: assert property (
    sys_req_i.valid && sys_req_i.addr[31:28] == 4'h1 && sys_req_i.addr[27:15] != 13'h0
    |=> sys_rsp_o.err)
    else $error("reserved address not refused");
  chk_main_served: assert property (
    rd_ok && main_a |=> !sys_rsp_o.err && !sys_rsp_o.pass)
    else $error("main flash read not served");
  chk_zero_flash: assert property (
    rd_ok && zero_a && !s_ff.zsel |=> !sys_rsp_o.err && !sys_rsp_o.pass)
    else $error("flash not at address zero");
  chk_zero_sram: assert property (
    rd_ok && zero_a && s_ff.zsel |=> sys_rsp_o.pass)
    else $error("sram not at address zero");
  chk_alias_read: assert property (
    reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o[0] == s_ff.zsel)
    else $error("alias select readback wrong");
  chk_debug_blocked: assert property (
    sys_req_i.valid && sys_req_i.debug && main_a && s_ff.prot |=> sys_rsp_o.err)
    else $error("debug read under protection served");
  chk_info_ro: assert property (
    sys_req_i.valid && sys_req_i.write && sys_req_i.addr[31:10] == 22'h100003
    |=> sys_rsp_o.err)
    else $error("info write not refused");
  chk_size_err: assert property (
    sys_req_i.valid && sys_req_i.size == 2'h3 |=> sys_rsp_o.err)
    else $error("illegal size not refused");
  chk_nmi_cause: assert property (
    $rose(nmi_o) |-> sys_rsp_o.valid || $past(sys_rsp_o.valid))
    else $error("nmi rose without an access");
  chk_nmi_holds: assert property (nmi_o && !reg_wr_i && !$past(reg_wr_i) |=> nmi_o)
    else $error("nmi dropped without a clear");
  chk_irq_cause: assert property (
    $rose(irq_o) |-> sys_rsp_o.valid || $past(sys_rsp_o.valid) || $past(reg_wr_i)
    || $past(reg_wr_i, 2))
    else $error("irq rose without a cause");
endmodule : flash_chk

bind flash_memory_access_ecc flash_chk u_flash_chk (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .sys_req_i, .sys_rsp_o, .irq_o, .nmi_o);

/* sys_bus_master.sv */
// Core and debug port model: one access at a time on the system port.
// Assumes the flash block answers one cycle after each request.
`timescale 1ns/100ps
module sys_bus_master (
  input wire logic clk_i,
  output flash_pkg::sys_req_t sys_req_o,
  input wire flash_pkg::sys_rsp_t sys_rsp_i
);
  import flash_pkg::*;
  initial sys_req_o = '0;
  ////////////////////////////////////////////////////////////////////////
  // Kind is {write, fetch, debug}; idle address is inverted so a stale one never matches
  task automatic access(input logic [31:0] a, input logic [2:0] kind, input logic [1:0] sz,
                        output sys_rsp_t r);
    @(posedge clk_i);
    sys_req_o <= '{1'b1, kind[2], kind[1], kind[0], sz, a};
    @(posedge clk_i);
    sys_req_o <= '{1'b0, 1'b0, 1'b0, 1'b0, 2'h0, ~a};
    #1;
    r = sys_rsp_i;
  endtask : access
endmodule : sys_bus_master

/* flash_memory_access_ecc_tb_top.sv */
// Testbench of the flash block: register tasks, bus model, random and corner cases.
// Assumes short write and erase counts so the run stays brief.
`timescale 1ns/100ps
module flash_memory_access_ecc_tb_top;
  import flash_pkg::*;
  localparam int WR_N = 5;
  localparam int ER_N = 20;
  localparam logic [31:0] GAPS [6] = '{32'h1000_8000, 32'h2000_0800, 32'h4000_0400,
                                      32'h4000_1C00, 32'hE010_0000, 32'h0000_8000};
  logic clk_i, rst_i, reg_wr_i, reg_rd_i, irq_o, nmi_o;
  logic [7:0] reg_addr_i;
  logic [31:0] reg_wdata_i, reg_rdata_o, d0, d, a, st;
  sys_req_t sys_req_i;
  sys_rsp_t sys_rsp_o, r;
  info_load_t info_load_i;
  int n_errors, check_count, cycles, seed, polls;
  flash_memory_access_ecc #(.WRITE_CYCLES(WR_N), .ERASE_CYCLES(ER_N)) u_flash_memory_access_ecc (
    .clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .sys_req_i, .sys_rsp_o, .info_load_i, .irq_o, .nmi_o);
  sys_bus_master u_sys_bus_master (.clk_i, .sys_req_o(sys_req_i), .sys_rsp_i(sys_rsp_o));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Whole run needs a few hundred cycles; the ceiling only catches a hang
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] page_last(input logic [31:0] ad);
    return {ad[31:9], 9'h1FC};
  endfunction : page_last
  task automatic results();
    if (n_errors == 0 && check_count > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      n_errors++;
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= wd;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] ad, output logic [31:0] q);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    q = reg_rdata_o;
  endtask : reg_rd
  task automatic rchk(input logic [7:0] ad, input logic [31:0] exp);
    reg_rd(ad, st);
    check("register", st, exp);
  endtask : rchk
  task automatic bus(input logic [31:0] ad, input logic [2:0] k, input logic [1:0] sz,
                     input logic [1:0] code, input logic [31:0] exp);
    u_sys_bus_master.access(ad, k, sz, r);
    check("bus code", {30'h0, r.err, r.pass}, {30'h0, code});
    if (code == 2'h0) check("bus data", r.data, exp);
  endtask : bus
  // Polls status every two cycles, so the busy span is known to within two cycles
  task automatic cmd(input logic [31:0] ad, input logic [31:0] wd, input logic [1:0] c,
                     input int n);
    reg_wr(8'h10, ad);
    reg_wr(8'h14, wd);
    reg_wr(8'h18, {30'h0, c});
    polls = 0;
    for (int i = 0; i < 100; i++)
    begin
      reg_rd(8'h1C, st);
      if (st[0] !== 1'b1) break;
      polls++;
    end
    if (n > 0)
      check("busy span", {31'h0, polls * 2 >= n - 1 && polls * 2 <= n + 2}, 32'h1);
  endtask : cmd
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 43915;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    rst_i = 1'b1;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 32'h0;
    info_load_i = '0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check("outputs", {29'h0, sys_rsp_o.valid, irq_o, nmi_o}, 32'h0);
    rchk(8'h00, 32'h0);
    rchk(8'h20, 32'h100);
    rchk(8'h40, 32'h0);
    d0 = $random(seed);
    cmd(32'h1000_0000, d0, 2'h1, WR_N);
    bus(32'h1000_0000, 3'h0, 2'h2, 2'h0, d0);
    for (int i = 0; i < 8; i++)
    begin
      a = {17'h2000, 6'(1 + ($unsigned($random(seed)) % 63)), 7'($random(seed)), 2'h0};
      d = $random(seed);
      cmd(a, d, 2'h1, WR_N);
      bus(a, {1'b0, i[0], 1'b0}, 2'(i % 3), 2'h0, d);
      bus({17'h0, a[14:0]}, 3'h0, 2'h2, 2'h0, d);
    end
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h0);
    cmd(a, 32'h0, 2'h2, ER_N);
    bus({a[31:9], 9'h0}, 3'h0, 2'h2, 2'h0, 32'hFFFF_FFFF);
    bus(page_last(a), 3'h0, 2'h0, 2'h0, 32'hFFFF_FFFF);
    bus(32'h1000_0000, 3'h0, 2'h2, 2'h0, d0);
    rchk(8'h08, 32'h1);
    check("irq", {31'h0, irq_o}, 32'h0);
    reg_wr(8'h0C, 32'h1);
    rchk(8'h0C, 32'h1);
    check("irq", {31'h0, irq_o}, 32'h1);
    check("nmi", {31'h0, nmi_o}, 32'h0);
    reg_wr(8'h08, 32'h1);
    rchk(8'h08, 32'h0);
    check("irq", {31'h0, irq_o}, 32'h0);
    bus({a[31:9], 9'h0}, 3'h2, 2'h2, 2'h0, 32'hFFFF_FFFF);
    rchk(8'h04, 32'h1);
    rchk(8'h08, 32'h0);
    check("nmi", {31'h0, nmi_o}, 32'h1);
    check("irq", {31'h0, irq_o}, 32'h0);
    reg_wr(8'h04, 32'h7);
    rchk(8'h04, 32'h0);
    check("nmi", {31'h0, nmi_o}, 32'h0);
    reg_wr(8'h00, 32'h1);
    rchk(8'h00, 32'h1);
    bus(32'h0000_0000, 3'h0, 2'h2, 2'h1, 32'h0);
    bus(32'h1000_0000, 3'h2, 2'h2, 2'h0, d0);
    reg_wr(8'h00, 32'h0);
    foreach (GAPS[i]) bus(GAPS[i], 3'h0, 2'h2, 2'h2, 32'h0);
    bus(32'h2000_0000, 3'h0, 2'h2, 2'h1, 32'h0);
    bus(32'h1000_0000, 3'h0, 2'h3, 2'h2, 32'h0);
    bus(32'h1000_0000, 3'h4, 2'h2, 2'h2, 32'h0);
    bus(32'h4000_0C00, 3'h4, 2'h2, 2'h2, 32'h0);
    d = $random(seed);
    @(posedge clk_i);
    info_load_i <= '{1'b1, 7'h05, d};
    @(posedge clk_i);
    info_load_i <= '0;
    bus(32'h4000_0C14, 3'h0, 2'h2, 2'h0, d);
    bus(32'h4000_0E14, 3'h0, 2'h2, 2'h0, d);
    bus(32'h1000_0000, 3'h1, 2'h2, 2'h0, d0);
    reg_wr(8'h20, 32'h101);
    bus(32'h1000_0000, 3'h1, 2'h2, 2'h2, 32'h0);
    bus(32'h1000_0000, 3'h0, 2'h2, 2'h0, d0);
    bus(32'h4000_0E14, 3'h1, 2'h2, 2'h0, d);
    cmd(32'h1000_0000, ~d0, 2'h1, 0);
    rchk(8'h1C, 32'h2);
    bus(32'h1000_0000, 3'h0, 2'h2, 2'h0, d0);
    cmd(32'h1000_0200, d, 2'h1, WR_N);
    rchk(8'h1C, 32'h0);
    bus(32'h1000_0200, 3'h0, 2'h2, 2'h0, d);
    cmd(32'h1000_0000, 32'h0, 2'h3, ER_N);
    bus(32'h1000_0200, 3'h0, 2'h2, 2'h0, 32'hFFFF_FFFF);
    bus(32'h1000_0000, 3'h0, 2'h2, 2'h0, d0);
    reg_wr(8'h20, 32'h0);
    rchk(8'h20, 32'h101);
    results();
  end
endmodule : flash_memory_access_ecc_tb_top
